// file: mic_pkg.sv
/*
 * mic_pkg: constants, register map and carrier types of the interrupt controller.
 * Assumes a 32-bit Avalon-MM register port and a 13-bit program counter in the core.
 */
package mic_pkg;

	// source order is also the fixed priority, index 0 highest
	localparam int NSRC = 7;
	localparam int SRC_EXT0 = 0;
	localparam int SRC_EXT1 = 1;
	localparam int SRC_CONV = 2;
	localparam int SRC_GRP0 = 3;
	localparam int NGRP_MAX = 4;
	localparam int NMEM = 4;
	localparam int PC_W = 13;
	localparam int ADDR_W = 5;
	localparam int SIDX_W = 3;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_FLAG = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_EDGE = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_GRP0 = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_GRP_STEP = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_GRP3 = 5'h18;
	localparam logic [ADDR_W-1:0] OFS_STAT = 5'h1C;

	// control register: per-source enables low, global enable on top
	localparam int CTRL_GIE = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [6:0] FLAG_RST = 7'h00;

	// group registers: member flags high nibble, member enables low nibble
	localparam int GRP_FLAG_LO = 4;
	localparam logic [NMEM-1:0] GRP_MASK [NGRP_MAX] = '{4'hF, 4'hF, 4'hF, 4'h3};
	localparam int LV_MEM = 0;
	localparam int SS_MEM = 1;
	localparam int XP_GRP = 1;
	localparam int XP_MEM = 1;

	// edge select: two bits per pin
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam logic [3:0] EDGE_RST = 4'h0;

	// status register fields
	localparam int STAT_SP_LO = 0;
	localparam int STAT_LP = 4;
	localparam int STAT_SRC_LO = 8;

	// vector addresses in priority order
	localparam logic [PC_W-1:0] VEC [NSRC] = '{13'h0004, 13'h0008, 13'h000C, 13'h0010,
		13'h0014, 13'h0018, 13'h001C};

	typedef struct packed {
		logic valid;
		logic [PC_W-1:0] addr;
	} mic_pc_load_s;

endpackage

// file: mic_intc.sv
/*
 * mic_intc: interrupt controller with flags, enables, shared-vector groups,
 * external edge detection, return stack, vectoring and wake-up from low power.
 * Assumes inputs synchronous to clk, one-cycle event pulses from the peripherals,
 * and a core that raises instr_boundary when an interrupt may be inserted.
 */

// Operation
// (RULE_01) third group register: second serial flag bit 5, enable bit 1
// (RULE_02) same register: low-voltage flag bit 4, enable bit 0, reset zero
// (RULE_03) bits 7:6 and 3:2 of third group register read zero
// (RULE_04) events set flags regardless of enable; jump needs individual enable
// (RULE_05) global enable low blocks every interrupt
// (RULE_06) taking an interrupt pushes next pc, then loads vector address
// (RULE_07) return from isr pops saved pc and resumes there
// (RULE_08) servicing clears global enable automatically
// (RULE_09) requests during blocking still set and hold their flags
// (RULE_10) software re-sets global enable in isr when nesting is wanted
// (RULE_11) full stack blocks acknowledge until stack pointer drops
// (RULE_12) simultaneous enabled requests resolved by fixed priority
// (RULE_13) a newly set flag wakes from sleep; already set ones do not
// (RULE_14) each external pin sets its flag on the configured edge
// (RULE_15) edge select offers rise, fall, both, or disabled
// (RULE_16) external pin acts only while its enable is set
// (RULE_17) servicing an external pin clears its flag and global enable
// (RULE_18) group flag set by member request; enabled group calls its vector
// (RULE_19) group service clears group flag only; members cleared by software
// (RULE_20) conversion done sets its flag; call needs global and own enable
// (RULE_21) servicing conversion done clears its flag and global enable
// (RULE_22) three or four shared-vector groups depending on variant
// (RULE_23) external peripheral falling edge sets flag; service leaves it set
// (RULE_24) priority order and vectors are fixed implementation constants
module mic_intc #(
	parameter int NGRP = 4,
	parameter int STACK_DEPTH = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [mic_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] ext_int_pins,
	input wire logic ext_periph_pin,
	input wire logic conv_done_evt,
	input wire logic [mic_pkg::NGRP_MAX*mic_pkg::NMEM-1:0] member_evt,
	input wire logic instr_boundary,
	input wire logic [mic_pkg::PC_W-1:0] next_pc,
	input wire logic call_push,
	input wire logic ret_pop,
	input wire logic return_from_isr_exec,
	input wire logic sleep_enter,
	output mic_pkg::mic_pc_load_s pc_load,
	output logic int_taken,
	output logic stack_full,
	output logic wake_up
);

	localparam int SP_W = $clog2(STACK_DEPTH + 1);
	localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);

	logic [7:0] ctrl;
	logic [6:0] flag;
	logic [3:0] edge_sel;
	logic [mic_pkg::NMEM-1:0] mem_flag [mic_pkg::NGRP_MAX];
	logic [mic_pkg::NMEM-1:0] mem_en [mic_pkg::NGRP_MAX];
	logic [mic_pkg::PC_W-1:0] stack [STACK_DEPTH];
	logic [SP_W-1:0] sp;
	logic [1:0] pin_prev;
	logic xp_prev;
	logic prev_ok;
	logic lp_mode;
	logic ack;
	logic [mic_pkg::SIDX_W-1:0] last_src;
	logic bus_wr;
	logic [7:0] wbyte;
	logic [6:0] src_set;
	logic [6:0] pend;
	logic take;
	logic core_free;
	logic [mic_pkg::SIDX_W-1:0] sel;
	logic [6:0] sel_onehot;
	logic [mic_pkg::NGRP_MAX*mic_pkg::NMEM-1:0] mem_set;
	logic [mic_pkg::NGRP_MAX-1:0] grp_set;
	logic [mic_pkg::NGRP_MAX*mic_pkg::NMEM-1:0] mem_rise;
	logic [mic_pkg::NGRP_MAX*mic_pkg::NMEM-1:0] mem_flag_all;
	logic [1:0] ext_edge;
	logic xp_fall;
	logic do_push;
	logic do_pop;
	logic [7:0] rd_byte;

	// bus slave: one wait cycle, write lands on the edge that ends the wait
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign bus_wr = avs_write & ack & avs_byteenable[0];
	assign wbyte = avs_writedata[7:0];

	always_ff @(posedge clk)
	begin
		if (!rstn)
			ack <= 1'b0;
		else
			ack <= (avs_read | avs_write) & ~ack;
	end

	// external pins: edge detect, blanked until a first sample is held
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			pin_prev <= 2'h0;
			xp_prev <= 1'b1;
			prev_ok <= 1'b0;
		end
		else
		begin
			pin_prev <= ext_int_pins;
			xp_prev <= ext_periph_pin;
			prev_ok <= 1'b1;
		end
	end

	generate
		for (genvar p = 0; p < 2; p++)
		begin : g_pin
			logic rise;
			logic fall;
			logic [1:0] mode;
			assign rise = prev_ok & ~pin_prev[p] & ext_int_pins[p];
			assign fall = prev_ok & pin_prev[p] & ~ext_int_pins[p];
			assign mode = edge_sel[2*p +: 2];
			// pin is an interrupt input only while its enable is set
			assign ext_edge[p] = ctrl[mic_pkg::SRC_EXT0 + p] & // RULE_16
				(((mode == mic_pkg::EDGE_RISE) | (mode == mic_pkg::EDGE_BOTH)) & rise |
				((mode == mic_pkg::EDGE_FALL) | (mode == mic_pkg::EDGE_BOTH)) & fall); // RULE_14 RULE_15
		end
	endgenerate

	assign xp_fall = prev_ok & xp_prev & ~ext_periph_pin; // RULE_23

	// member events, with the external peripheral edge folded into its slot
	always_comb
	begin
		mem_set = member_evt;
		mem_set[mic_pkg::XP_GRP*mic_pkg::NMEM + mic_pkg::XP_MEM] = xp_fall; // RULE_23
	end

	// member flags set whatever the enable; group flag needs the member enable
	generate
		for (genvar g = 0; g < mic_pkg::NGRP_MAX; g++)
		begin : g_grp
			localparam logic [mic_pkg::NMEM-1:0] MASK = (g < NGRP) ? mic_pkg::GRP_MASK[g] : 4'h0;
			localparam logic [mic_pkg::ADDR_W-1:0] OFS = mic_pkg::ADDR_W'(
				mic_pkg::OFS_GRP0 + g * mic_pkg::OFS_GRP_STEP);
			logic [mic_pkg::NMEM-1:0] ev;
			logic hit;
			assign ev = mem_set[g*mic_pkg::NMEM +: mic_pkg::NMEM] & MASK;
			assign hit = bus_wr & (avs_address == OFS);
			assign mem_rise[g*mic_pkg::NMEM +: mic_pkg::NMEM] = ev & ~mem_flag[g];
			assign mem_flag_all[g*mic_pkg::NMEM +: mic_pkg::NMEM] = mem_flag[g];
			assign grp_set[g] = |(ev & mem_en[g]); // RULE_18 RULE_22

			always_ff @(posedge clk)
			begin
				if (!rstn)
				begin
					mem_flag[g] <= 4'h0; // RULE_02
					mem_en[g] <= 4'h0;
				end
				else
				begin
					// set wins over a software clear; unimplemented bits stay zero
					mem_flag[g] <= ((hit ? wbyte[mic_pkg::GRP_FLAG_LO +: mic_pkg::NMEM] :
						mem_flag[g]) | ev) & MASK; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_19
					if (hit)
						mem_en[g] <= wbyte[mic_pkg::NMEM-1:0] & MASK; // RULE_01 RULE_02 RULE_03
				end
			end
		end
	endgenerate

	// hardware set events per top-level source
	always_comb
	begin
		src_set = 7'h00;
		src_set[mic_pkg::SRC_EXT0] = ext_edge[0];
		src_set[mic_pkg::SRC_EXT1] = ext_edge[1];
		src_set[mic_pkg::SRC_CONV] = conv_done_evt; // RULE_20
		src_set[mic_pkg::SRC_GRP0 +: mic_pkg::NGRP_MAX] = grp_set;
	end

	// fixed priority pick among enabled pending sources
	assign pend = flag & ctrl[6:0]; // RULE_04 RULE_20
	always_comb
	begin
		sel = '0;
		for (int i = mic_pkg::NSRC - 1; i >= 0; i--)
		begin
			if (pend[i])
				sel = mic_pkg::SIDX_W'(i); // RULE_12 RULE_24
		end
	end

	always_comb
	begin
		sel_onehot = 7'h00;
		sel_onehot[sel] = 1'b1;
	end

	// the core must not be mid call or return when the vector is inserted
	assign core_free = instr_boundary & ~call_push & ~ret_pop & ~return_from_isr_exec;
	assign stack_full = (sp == SP_FULL);
	assign take = ctrl[mic_pkg::CTRL_GIE] & (|pend) & ~stack_full & core_free; // RULE_05 RULE_11
	assign int_taken = take;

	// flags: software write, service clear, then hardware set wins
	always_ff @(posedge clk)
	begin
		if (!rstn)
			flag <= mic_pkg::FLAG_RST;
		else
			flag <= ((bus_wr & (avs_address == mic_pkg::OFS_FLAG)) ? wbyte[6:0] : flag) &
				~(take ? sel_onehot : 7'h00) | src_set; // RULE_09 RULE_17 RULE_19 RULE_21
	end

	// control: service clears the global enable and beats a same-edge write
	always_ff @(posedge clk)
	begin
		if (!rstn)
			ctrl <= mic_pkg::CTRL_RST;
		else
		begin
			if (bus_wr & (avs_address == mic_pkg::OFS_CTRL))
				ctrl <= wbyte;
			if (take)
				ctrl[mic_pkg::CTRL_GIE] <= 1'b0; // RULE_08 RULE_17 RULE_21
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			edge_sel <= mic_pkg::EDGE_RST;
		else if (bus_wr & (avs_address == mic_pkg::OFS_EDGE))
			edge_sel <= wbyte[3:0]; // RULE_15
	end

	// return stack; pushes beyond depth are dropped, pops of empty ignored
	assign do_push = (take | call_push) & ~stack_full;
	assign do_pop = (ret_pop | return_from_isr_exec) & (sp != '0);

	always_ff @(posedge clk)
	begin
		if (!rstn)
			sp <= '0;
		else if (do_push)
			sp <= sp + SP_W'(1); // RULE_06
		else if (do_pop)
			sp <= sp - SP_W'(1); // RULE_07 RULE_11
	end

	always_ff @(posedge clk)
	begin
		if (do_push)
			stack[sp[$clog2(STACK_DEPTH)-1:0]] <= next_pc; // RULE_06
	end

	// pc load: vector on take, saved pc on return
	always_ff @(posedge clk)
	begin
		if (!rstn)
			pc_load <= '0;
		else if (take)
		begin
			pc_load.valid <= 1'b1;
			pc_load.addr <= mic_pkg::VEC[sel]; // RULE_06 RULE_24
		end
		else if (do_pop)
		begin
			pc_load.valid <= 1'b1;
			pc_load.addr <= stack[sp[$clog2(STACK_DEPTH)-1:0] - 1'b1]; // RULE_07
		end
		else
			pc_load.valid <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			last_src <= '0;
		else if (take)
			last_src <= sel;
	end

	// low power: only a flag going from clear to set wakes the device
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			lp_mode <= 1'b0;
			wake_up <= 1'b0;
		end
		else
		begin
			wake_up <= lp_mode & ((|(src_set & ~flag)) | (|mem_rise)); // RULE_13
			if (sleep_enter)
				lp_mode <= 1'b1;
			else if (wake_up)
				lp_mode <= 1'b0;
		end
	end

	// read mux, unmapped offsets read zero
	always_comb
	begin
		rd_byte = 8'h00;
		case (avs_address)
			mic_pkg::OFS_CTRL: rd_byte = ctrl;
			mic_pkg::OFS_FLAG: rd_byte = {1'b0, flag};
			mic_pkg::OFS_EDGE: rd_byte = {4'h0, edge_sel};
			mic_pkg::OFS_STAT: rd_byte = 8'(sp) | (8'(lp_mode) << mic_pkg::STAT_LP);
			default:
			begin
				for (int g = 0; g < mic_pkg::NGRP_MAX; g++)
				begin
					if (avs_address == mic_pkg::ADDR_W'(mic_pkg::OFS_GRP0 +
						g * mic_pkg::OFS_GRP_STEP))
						rd_byte = {mem_flag[g], mem_en[g]}; // RULE_03
				end
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read & ~ack)
			avs_readdata <= (avs_address == mic_pkg::OFS_STAT) ?
				{21'h0, last_src, rd_byte} : {24'h0, rd_byte};
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	gie_blocks_take_a: assert property (!ctrl[mic_pkg::CTRL_GIE] |-> !int_taken) // RULE_05
		else $error("interrupt taken with global enable low");
	take_clears_gie_a: assert property (int_taken |=> !ctrl[mic_pkg::CTRL_GIE]) // RULE_08
		else $error("global enable not cleared after service");
	full_stack_block_a: assert property (stack_full |-> !int_taken) // RULE_11
		else $error("interrupt taken with full stack");
	take_needs_enable_a: assert property (int_taken |-> (flag[sel] && ctrl[sel])) // RULE_04
		else $error("interrupt taken for a disabled source");
	vector_load_a: assert property (int_taken |=> pc_load.valid &&
		pc_load.addr == mic_pkg::VEC[$past(sel)] && sp == $past(sp) + SP_W'(1)) // RULE_06
		else $error("vector or push wrong after take");
	return_from_isr_pop_a: assert property (return_from_isr_exec && sp != '0 |=> pc_load.valid &&
		sp == $past(sp) - SP_W'(1)) // RULE_07
		else $error("return did not pop the stack");
	group3_reserved_a: assert property (((mem_flag[3] | mem_en[3]) & 4'hC) == 4'h0) // RULE_03
		else $error("unimplemented group three bit set");
	conv_flag_set_a: assert property (conv_done_evt |=> flag[mic_pkg::SRC_CONV]) // RULE_20
		else $error("conversion done flag not set");
	ext_disabled_a: assert property (!ctrl[mic_pkg::SRC_EXT0] && !flag[mic_pkg::SRC_EXT0] &&
		!(bus_wr && avs_address == mic_pkg::OFS_FLAG) |=> !flag[mic_pkg::SRC_EXT0]) // RULE_16
		else $error("disabled external pin raised its flag");
	// member flags may gain bits on a new event, but service never drops one
	group_service_a: assert property (int_taken && sel >= mic_pkg::SIDX_W'(mic_pkg::SRC_GRP0) &&
		!bus_wr |=> (mem_flag_all & $past(mem_flag_all)) == $past(mem_flag_all)) // RULE_19
		else $error("member flags changed by group service");
	wake_quiet_a: assert property (lp_mode && src_set == 7'h00 && mem_set == '0
		|=> !wake_up) // RULE_13
		else $error("wake without a new flag");

	take_group_c: cover property (int_taken && sel >= mic_pkg::SIDX_W'(mic_pkg::SRC_GRP0));
	take_return_from_isr_c: cover property (int_taken ##[1:40] return_from_isr_exec);
	wake_c: cover property (lp_mode ##1 wake_up);
	blocked_full_c: cover property (stack_full && |pend && ctrl[mic_pkg::CTRL_GIE]);

endmodule

// file: mic_core_model.sv
/*
 * mic_core_model: behavioural program sequencer and stack user facing the controller.
 * Assumes the bench shares clk with the controller and asks for core strobes through req.
 */
module mic_core_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] req,
	input wire mic_pkg::mic_pc_load_s pc_load,
	output logic instr_boundary,
	output logic [mic_pkg::PC_W-1:0] next_pc,
	output logic call_push,
	output logic ret_pop,
	output logic return_from_isr_exec,
	output logic sleep_enter
);
	timeunit 1ns;
	timeprecision 1ns;

	// pc jumps on a load, else steps each cycle so every pushed value differs
	always_ff @(posedge clk)
	begin
		if (!rstn)
			next_pc <= 13'h0100;
		else if (pc_load.valid)
			next_pc <= pc_load.addr;
		else
			next_pc <= next_pc + 13'h0001;
	end

	// strobes leave on an edge; req packs sleep, return_from_isr, pop, push from the top
	always_ff @(posedge clk)
	begin
		if (!rstn)
			{sleep_enter, return_from_isr_exec, ret_pop, call_push} <= 4'h0;
		else
			{sleep_enter, return_from_isr_exec, ret_pop, call_push} <= req;
	end

	// every cycle a boundary: the widest window for the controller to take in
	assign instr_boundary = 1'b1;
endmodule

// file: mic_intc_bench.sv
/*
 * mic_intc_bench: self-checking bench for the interrupt controller over Avalon-MM.
 * Assumes mic_core_model as the core and the register layout of mic_pkg.
 */
module mic_intc_bench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [3:0] PUSH = 4'h1;
	localparam logic [3:0] POP = 4'h2;
	localparam logic [3:0] RETURN_FROM_ISR = 4'h4;
	localparam logic [3:0] SLEEP = 4'h8;
	localparam logic [4:0] RISE_HIT = 5'h0A;
	localparam logic [4:0] FALL_HIT = 5'h0E;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rdv;
	logic avs_waitrequest, instr_boundary, call_push, ret_pop, return_from_isr_exec, sleep_enter;
	logic int_taken, stack_full, wake_up;
	logic [1:0] ext_int_pins = 2'h0;
	logic ext_periph_pin = 1'b1;
	logic conv_done_evt = 1'b0;
	logic [15:0] member_evt = 16'h0;
	logic [3:0] req = 4'h0;
	logic [12:0] next_pc, sv, ld;
	mic_pkg::mic_pc_load_s pc_load;
	logic [1:0] modes [5] = '{mic_pkg::EDGE_OFF, mic_pkg::EDGE_RISE, mic_pkg::EDGE_FALL,
		mic_pkg::EDGE_BOTH, mic_pkg::EDGE_BOTH};
	int err_count = 0;
	int cmp_count = 0;
	int tk = 0;
	int wk = 0;

	mic_intc #(.NGRP(4), .STACK_DEPTH(8)) dut (.clk, .rstn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .ext_int_pins,
		.ext_periph_pin, .conv_done_evt, .member_evt, .instr_boundary, .next_pc, .call_push,
		.ret_pop, .return_from_isr_exec, .sleep_enter, .pc_load, .int_taken, .stack_full, .wake_up);
	mic_core_model core_i (.clk, .rstn, .req, .pc_load, .instr_boundary, .next_pc, .call_push,
		.ret_pop, .return_from_isr_exec, .sleep_enter);

	always #25 clk = ~clk;

	// negedge sampling stays clear of the edge where the controller updates
	always @(negedge clk)
	begin
		if (int_taken)
		begin
			tk++;
			sv = next_pc;
		end
		if (pc_load.valid)
			ld = pc_load.addr;
		if (wake_up)
			wk++;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t ns: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// request held until waitrequest is sampled low at a rising edge, released on that edge
	task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rdv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task wr(input logic [4:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask

	task rd(input logic [4:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk(rdv, {24'h000000, exp});
	endtask

	task ev(input logic [16:0] v);
		@(posedge clk);
		{conv_done_evt, member_evt} <= v;
		@(posedge clk);
		{conv_done_evt, member_evt} <= 17'h00000;
		repeat (2) @(posedge clk);
	endtask

	task core(input logic [3:0] r);
		@(posedge clk);
		req <= r;
		@(posedge clk);
		req <= 4'h0;
		repeat (4) @(posedge clk);
	endtask

	// one take, then the vector of source i on the load that follows it
	task see_take(input int i);
		repeat (12)
			if (tk == 0)
				@(negedge clk);
		repeat (2) @(negedge clk);
		chk(tk, 1);
		chk(ld, mic_pkg::VEC[i]);
	endtask

	task close_out();
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd(5'h02, 8'h00);
		rd(mic_pkg::OFS_GRP3, 8'h00);
		// conversion flag with enables off, then held back by the global enable
		ev(17'h10000);
		rd(mic_pkg::OFS_FLAG, 8'h04);
		tk = 0;
		wr(mic_pkg::OFS_CTRL, 8'h04);
		repeat (6) @(negedge clk);
		chk(tk, 0);
		rd(mic_pkg::OFS_FLAG, 8'h04);
		wr(mic_pkg::OFS_CTRL, 8'h84);
		see_take(mic_pkg::SRC_CONV);
		rd(mic_pkg::OFS_FLAG, 8'h00);
		rd(mic_pkg::OFS_CTRL, 8'h04);
		core(RETURN_FROM_ISR);
		chk(ld, sv);
		// two pending at once, global enable set again inside the routine
		wr(mic_pkg::OFS_FLAG, 8'h05);
		tk = 0;
		wr(mic_pkg::OFS_CTRL, 8'h85);
		see_take(mic_pkg::SRC_EXT0);
		rd(mic_pkg::OFS_FLAG, 8'h04);
		tk = 0;
		wr(mic_pkg::OFS_CTRL, 8'h85);
		see_take(mic_pkg::SRC_CONV);
		// every edge mode on both pins, last pass with the pin enables off
		for (int m = 0; m < 5; m++)
		begin
			wr(mic_pkg::OFS_CTRL, (m < 4) ? 8'h03 : 8'h00);
			wr(mic_pkg::OFS_EDGE, {4'h0, modes[m], modes[m]});
			wr(mic_pkg::OFS_FLAG, 8'h00);
			ext_int_pins <= 2'h3;
			repeat (3) @(posedge clk);
			rd(mic_pkg::OFS_FLAG, {6'h00, RISE_HIT[m], RISE_HIT[m]});
			ext_int_pins <= 2'h0;
			repeat (3) @(posedge clk);
			rd(mic_pkg::OFS_FLAG, {6'h00, FALL_HIT[m], FALL_HIT[m]});
		end
		// shared group three: low voltage, then second serial port
		wr(mic_pkg::OFS_CTRL, 8'hC0);
		wr(mic_pkg::OFS_GRP3, 8'h01);
		tk = 0;
		ev(17'h01000);
		see_take(mic_pkg::SRC_GRP0 + 3);
		rd(mic_pkg::OFS_GRP3, 8'h11);
		rd(mic_pkg::OFS_FLAG, 8'h00);
		wr(mic_pkg::OFS_GRP3, 8'h02);
		ev(17'h02000);
		rd(mic_pkg::OFS_GRP3, 8'h22);
		wr(mic_pkg::OFS_GRP3, 8'h00);
		// external peripheral falling edge through group one
		wr(mic_pkg::OFS_GRP0 + mic_pkg::OFS_GRP_STEP, 8'h02);
		ext_periph_pin <= 1'b0;
		repeat (3) @(posedge clk);
		tk = 0;
		wr(mic_pkg::OFS_CTRL, 8'h90);
		see_take(mic_pkg::SRC_GRP0 + 1);
		rd(mic_pkg::OFS_GRP0 + mic_pkg::OFS_GRP_STEP, 8'h22);
		// fill the stack, then free one slot
		for (int i = 0; i < 8; i++)
			if (stack_full !== 1'b1)
				core(PUSH);
		chk(stack_full, 1);
		wr(mic_pkg::OFS_FLAG, 8'h04);
		tk = 0;
		wr(mic_pkg::OFS_CTRL, 8'h84);
		repeat (6) @(negedge clk);
		chk(tk, 0);
		core(POP);
		see_take(mic_pkg::SRC_CONV);
		// a flag already set sleeps on, a fresh one wakes
		wr(mic_pkg::OFS_CTRL, 8'h00);
		wr(mic_pkg::OFS_FLAG, 8'h04);
		core(SLEEP);
		wk = 0;
		ev(17'h10000);
		chk(wk, 0);
		ev(17'h01000);
		repeat (2) @(negedge clk);
		chk(wk, 1);
		close_out();
	end

	// the sequence needs about 300 cycles; a hang ends it here
	initial
	begin
		repeat (5000) @(posedge clk);
		err_count++;
		close_out();
	end
endmodule
